// *** rtl/ttw_walk.sv ***
// Operation
// - Tree depth zero to five, six via indirection
// - Zero levels: root terminates, limit check only
// - Initial shift drops top bits, never checked
// - Function-code table has no size limit
// - Table descriptor limit bounds next index
// - Page in pointer table ends walk early
// - Early-termination limit shrinks mapped block
// - One cache entry per page on access
// - Table entry in page table is indirect
// - Access sets used flag in final descriptor
// - Write also sets modified flag
// - Invalid recognised from type bits only
// - Table bases aligned to sixteen bytes
`timescale 1ns/1ps
`default_nettype none
`include "ttw_map.svh"
module ttw_walk
  import ttw_pkg::*;
#(
  parameter int LV = 5
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core walk request
  input wire logic walk_req,
  input wire logic [31:0] walk_vaddr,
  input wire logic walk_write,
  input wire logic [2:0] walk_fc,
  output logic walk_busy,
  output logic walk_fault,
  // Translation cache fill
  output logic cache_fill_valid,
  output logic [31:0] cache_fill_vpage,
  output logic [31:0] cache_fill_ppage,
  // Descriptor memory
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // Interrupt
  output logic irq
);
  // Configuration registers
  logic [`TTW_CTRL_W-1:0] ctrl_q; // Translation control
  logic [`TTW_WIDTHS_W-1:0] widths_q; // Index widths per level
  logic [31:0] root_q; // Root table base
  logic [`TTW_LIM_W-1:0] rlim_q; // Root limit
  logic rlu_q; // Root limit is lower bound
  // APB answer flops
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  // Walk state
  ttw_state_e st_q;
  ttw_cause_e cause_q;
  logic [31:0] va_q; // Address under walk
  logic wr_q; // Access is a write
  logic [2:0] fc_q; // Access function code
  logic [31:0] base_q; // Current table base
  logic long_q; // Current entries are long
  logic [`TTW_LIM_W-1:0] lim_q; // Current table limit
  logic lu_q; // Limit is lower bound
  logic limv_q; // Limit applies
  logic fcp_q; // Next table indexed by function code
  logic indir_q; // Following an indirect pointer
  logic [2:0] cons_q; // Address levels consumed
  logic [31:0] ea_q; // Descriptor address
  logic [31:0] w0_q; // Descriptor first word
  logic [31:0] w1_q; // Descriptor second word
  logic [31:0] pa_q; // Translated address
  logic [31:0] fva_q; // Last faulting address
  // Output flops
  logic busy_q;
  logic fault_q;
  logic fill_q;
  logic [31:0] vpage_q;
  logic [31:0] ppage_q;
  logic mem_req_q;
  logic mem_we_q;
  logic [31:0] mem_addr_q;
  logic [31:0] mem_wdata_q;
  // Interrupt block state
  logic [`TTW_NEV-1:0] status_w;
  logic [`TTW_NEV-1:0] mask_w;
  logic irq_w;

  // Control fields
  wire en_w = ctrl_q[`TTW_CTRL_EN];
  wire fcl_w = ctrl_q[`TTW_CTRL_FCL];
  wire [3:0] shift_w = ctrl_q[`TTW_CTRL_SH_LSB +: 4];
  wire [2:0] lv_w = ctrl_q[`TTW_CTRL_LV_LSB +: 3];

  // APB decode
  wire apb_setup = psel & penable & ~pready_q;
  wire apb_wr = psel & penable & pready_q & pwrite;
  wire hit_ctrl = paddr == `TTW_A_CTRL;
  wire hit_wid = paddr == `TTW_A_WIDTHS;
  wire hit_root = paddr == `TTW_A_ROOT;
  wire hit_rlim = paddr == `TTW_A_ROOTLIM;
  wire hit_stat = paddr == `TTW_A_STATUS;
  wire hit_mask = paddr == `TTW_A_MASK;
  wire hit_fva = paddr == `TTW_A_FVADDR;
  wire hit_wst = paddr == `TTW_A_WSTATE;
  wire hit_any = hit_ctrl | hit_wid | hit_root | hit_rlim | hit_stat | hit_mask | hit_fva | hit_wst;
  wire [2:0] lv_wr = (pwdata[`TTW_CTRL_LV_LSB +: 3] > `TTW_MAX_LEVELS) ? `TTW_MAX_LEVELS
                     : pwdata[`TTW_CTRL_LV_LSB +: 3];
  wire [31:0] wst_w = {22'h0, cause_q, 1'b0, cons_q, 1'b0, st_q};
  wire [31:0] rd_mux = hit_ctrl ? {21'h0, ctrl_q}
                     : hit_wid ? {12'h0, widths_q}
                     : hit_root ? root_q
                     : hit_rlim ? {rlu_q, 16'h0, rlim_q}
                     : hit_stat ? {30'h0, status_w}
                     : hit_mask ? {30'h0, mask_w}
                     : hit_fva ? fva_q
                     : hit_wst ? wst_w : 32'h0;

  // APB answer: one wait state, then pready with data
  always_ff @(posedge mclk) begin
    if (srst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= apb_setup;
      pslverr_q <= apb_setup & ~hit_any;
      prdata_q <= apb_setup ? rd_mux : 32'h0;
    end
  end

  // Configuration writes
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_q <= `TTW_CTRL_RST;
      widths_q <= '0;
      root_q <= 32'h0;
      rlim_q <= '0;
      rlu_q <= 1'b0;
    end else begin
      if (apb_wr && hit_ctrl) begin
        ctrl_q <= {lv_wr, pwdata[7:0]};
      end
      if (apb_wr && hit_wid) begin
        widths_q <= pwdata[`TTW_WIDTHS_W-1:0];
      end
      if (apb_wr && hit_root) begin
        root_q <= {pwdata[31:4], 4'h0};
      end
      if (apb_wr && hit_rlim) begin
        rlu_q <= pwdata[31];
        rlim_q <= pwdata[`TTW_LIM_W-1:0];
      end
    end
  end

  // Index and masks for the level about to be used
  logic [14:0] idx_w;
  logic [31:0] offs_w;
  logic [31:0] pmask_w;
  ttw_index #(.LV(LV)) u_index (
    .vaddr(va_q),
    .shift(shift_w),
    .widths(widths_q),
    .nsel(cons_q),
    .nlev(lv_w),
    .idx(idx_w),
    .offs_mask(offs_w),
    .page_mask(pmask_w)
  );

  // Table entry address, function-code tables ignore limits
  wire [14:0] ent_idx = fcp_q ? {12'h0, fc_q} : idx_w;
  wire [31:0] ent_off = long_q ? {14'h0, ent_idx, 3'h0} : {15'h0, ent_idx, 2'h0};
  wire [31:0] ent_addr = base_q + ent_off;
  wire tbl_lim_bad = limv_q & ~fcp_q & (lu_q ? (idx_w < lim_q) : (idx_w > lim_q));
  // Zero-level tree terminates at the root pointer
  wire root_term = (cons_q == lv_w) & ~fcp_q;
  wire [31:0] root_pa = root_q + (va_q & offs_w);
  wire root_bad = rlu_q ? (root_pa[31:17] < rlim_q) : (root_pa[31:17] > rlim_q);

  // Descriptor decode
  wire [1:0] dt = w0_q[1:0];
  wire last = (cons_q == lv_w);
  wire [31:0] nb = long_q ? w1_q : w0_q;
  wire [31:0] tbl_base = {nb[31:4], 4'h0};
  wire [31:0] ind_addr = dt[0] ? {nb[31:3], 3'h0} : {nb[31:2], 2'h0};
  wire [`TTW_LIM_W-1:0] d_lim = w0_q[`TTW_D_LIM_LSB +: `TTW_LIM_W];
  wire d_lu = w0_q[`TTW_D_LU];
  wire et_bad = long_q & (d_lu ? (idx_w < d_lim) : (idx_w > d_lim));
  wire [31:0] page_pa = {nb[31:8], 8'h0} + (va_q & offs_w);
  wire need_upd = ~w0_q[`TTW_D_USED] | (wr_q & ~w0_q[`TTW_D_MOD]);
  wire [31:0] upd_word = w0_q | (32'h1 << `TTW_D_USED) | (wr_q ? (32'h1 << `TTW_D_MOD) : 32'h0);
  wire start = (st_q == ST_IDLE) & walk_req & en_w;

  // Walk sequencer
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q <= ST_IDLE;
      cause_q <= FC_NONE;
      {va_q, wr_q, fc_q, base_q, long_q, lim_q, lu_q, limv_q} <= '0;
      {fcp_q, indir_q, cons_q, ea_q, w0_q, w1_q, pa_q, fva_q} <= '0;
      {mem_req_q, mem_we_q, mem_addr_q, mem_wdata_q, busy_q} <= '0;
    end else begin
      case (st_q)
        // Latch request, begin at the root
        ST_IDLE: begin
          if (start) begin
            va_q <= walk_vaddr;
            wr_q <= walk_write;
            fc_q <= walk_fc;
            base_q <= root_q;
            long_q <= 1'b1;
            lim_q <= rlim_q;
            lu_q <= rlu_q;
            limv_q <= 1'b1;
            fcp_q <= fcl_w;
            indir_q <= 1'b0;
            cons_q <= 3'h0;
            busy_q <= 1'b1;
            st_q <= ST_ISSUE;
          end
        end
        // Check the index and fetch the entry
        ST_ISSUE: begin
          if (root_term) begin
            pa_q <= root_pa;
            cause_q <= root_bad ? FC_LIMIT : cause_q;
            st_q <= root_bad ? ST_FAULT : ST_FILL;
          end else if (tbl_lim_bad) begin
            cause_q <= FC_LIMIT;
            st_q <= ST_FAULT;
          end else begin
            ea_q <= ent_addr;
            mem_addr_q <= ent_addr;
            mem_we_q <= 1'b0;
            mem_req_q <= 1'b1;
            cons_q <= fcp_q ? cons_q : cons_q + 3'h1;
            fcp_q <= 1'b0;
            st_q <= ST_RD0;
          end
        end
        // First descriptor word
        ST_RD0: begin
          if (mem_ack) begin
            w0_q <= mem_rdata;
            if (long_q) begin
              mem_addr_q <= ea_q + 32'h4;
              st_q <= ST_RD1;
            end else begin
              mem_req_q <= 1'b0;
              st_q <= ST_DECIDE;
            end
          end
        end
        // Second word of a long descriptor
        ST_RD1: begin
          if (mem_ack) begin
            w1_q <= mem_rdata;
            mem_req_q <= 1'b0;
            st_q <= ST_DECIDE;
          end
        end
        // Act on the descriptor type
        ST_DECIDE: begin
          case (dt)
            `TTW_DT_INV: begin
              cause_q <= FC_INVALID;
              st_q <= ST_FAULT;
            end
            `TTW_DT_PAGE: begin
              if (!indir_q && !last && et_bad) begin
                cause_q <= FC_LIMIT;
                st_q <= ST_FAULT;
              end else begin
                pa_q <= page_pa;
                if (need_upd) begin
                  mem_addr_q <= ea_q;
                  mem_wdata_q <= upd_word;
                  mem_we_q <= 1'b1;
                  mem_req_q <= 1'b1;
                  st_q <= ST_UPD;
                end else begin
                  st_q <= ST_FILL;
                end
              end
            end
            default: begin
              if (indir_q) begin
                cause_q <= FC_INDIRECT;
                st_q <= ST_FAULT;
              end else if (last) begin
                indir_q <= 1'b1;
                long_q <= dt[0];
                ea_q <= ind_addr;
                mem_addr_q <= ind_addr;
                mem_we_q <= 1'b0;
                mem_req_q <= 1'b1;
                st_q <= ST_RD0;
              end else begin
                base_q <= tbl_base;
                long_q <= dt[0];
                limv_q <= long_q;
                lim_q <= d_lim;
                lu_q <= d_lu;
                st_q <= ST_ISSUE;
              end
            end
          endcase
        end
        // Write back used and modified flags
        ST_UPD: begin
          if (mem_ack) begin
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
            st_q <= ST_FILL;
          end
        end
        // Hand one page to the cache
        ST_FILL: begin
          busy_q <= 1'b0;
          st_q <= ST_IDLE;
        end
        // Report and drop the walk
        ST_FAULT: begin
          fva_q <= va_q;
          busy_q <= 1'b0;
          st_q <= ST_IDLE;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Result pulses, one page per fill
  always_ff @(posedge mclk) begin
    if (srst) begin
      fill_q <= 1'b0;
      fault_q <= 1'b0;
      vpage_q <= 32'h0;
      ppage_q <= 32'h0;
    end else begin
      fill_q <= st_q == ST_FILL;
      fault_q <= st_q == ST_FAULT;
      vpage_q <= (st_q == ST_FILL) ? (va_q & ~pmask_w) : vpage_q;
      ppage_q <= (st_q == ST_FILL) ? (pa_q & ~pmask_w) : ppage_q;
    end
  end

  // Sticky events and interrupt
  ttw_irq #(.N(`TTW_NEV)) u_irq (
    .mclk(mclk),
    .srst(srst),
    .ev_set({fault_q, fill_q}),
    .clr_we(apb_wr & hit_stat),
    .mask_we(apb_wr & hit_mask),
    .wdata(pwdata[`TTW_NEV-1:0]),
    .status_q(status_w),
    .mask_q(mask_w),
    .irq_q(irq_w)
  );

  // Port drive
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign walk_busy = busy_q;
  assign walk_fault = fault_q;
  assign cache_fill_valid = fill_q;
  assign cache_fill_vpage = vpage_q;
  assign cache_fill_ppage = ppage_q;
  assign mem_req = mem_req_q;
  assign mem_we = mem_we_q;
  assign mem_addr = mem_addr_q;
  assign mem_wdata = mem_wdata_q;
  assign irq = irq_w;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_depth_bound: assert property (cons_q <= `TTW_MAX_LEVELS)
    else $error("walk depth beyond five levels");
  a_root_term: assert property ((st_q == ST_ISSUE && root_term) |=> (st_q inside {ST_FILL, ST_FAULT}) && !mem_req_q)
    else $error("root termination fetched memory");
  a_fc_nolimit: assert property ((st_q == ST_ISSUE && fcp_q && !root_term) |=> st_q == ST_RD0)
    else $error("function code table refused");
  a_limit_fault: assert property ((st_q == ST_ISSUE && !root_term && tbl_lim_bad) |=> st_q == ST_FAULT ##1 walk_fault)
    else $error("limit violation not faulted");
  a_indirect_go: assert property ((st_q == ST_DECIDE && last && dt[1] && !indir_q) |=> indir_q && st_q == ST_RD0)
    else $error("indirect descriptor not followed");
  a_used_flag: assert property ((st_q == ST_UPD) |-> mem_we_q && mem_wdata_q[`TTW_D_USED])
    else $error("used flag not written");
  a_mod_flag: assert property ((st_q == ST_UPD && wr_q) |-> mem_wdata_q[`TTW_D_MOD])
    else $error("modified flag not written");
  a_invalid_fault: assert property ((st_q == ST_DECIDE && dt == `TTW_DT_INV) |=> st_q == ST_FAULT ##1 !cache_fill_valid)
    else $error("invalid descriptor not faulted");
  a_base_align: assert property ((st_q == ST_ISSUE) |-> base_q[3:0] == 4'h0)
    else $error("table base not aligned");
  a_fill_single: assert property (cache_fill_valid |=> !cache_fill_valid && !walk_fault)
    else $error("fill longer than one page pulse");
endmodule
`default_nettype wire

// *** rtl/ttw_map.svh ***
`ifndef TTW_MAP_SVH
`define TTW_MAP_SVH

// Register byte offsets on the APB window
`define TTW_A_CTRL 8'h00
`define TTW_A_WIDTHS 8'h04
`define TTW_A_ROOT 8'h08
`define TTW_A_ROOTLIM 8'h0c
`define TTW_A_STATUS 8'h10
`define TTW_A_MASK 8'h14
`define TTW_A_FVADDR 8'h18
`define TTW_A_WSTATE 8'h1c

// Control register fields
`define TTW_CTRL_EN 0
`define TTW_CTRL_FCL 1
`define TTW_CTRL_SH_LSB 4
`define TTW_CTRL_LV_LSB 8
`define TTW_CTRL_W 11
`define TTW_CTRL_RST 11'h000

// Level count limit and index field width per level
`define TTW_MAX_LEVELS 3'h5
`define TTW_WIDTHS_W 20
`define TTW_LIM_W 15

// Descriptor type codes, flag bits, long-format limit fields
`define TTW_DT_INV 2'h0
`define TTW_DT_PAGE 2'h1
`define TTW_DT_TSHORT 2'h2
`define TTW_DT_TLONG 2'h3
`define TTW_D_USED 3
`define TTW_D_MOD 4
`define TTW_D_LU 31
`define TTW_D_LIM_LSB 16

// Status bit positions
`define TTW_ST_FILL 0
`define TTW_ST_FAULT 1
`define TTW_NEV 2

`endif

// *** rtl/ttw_pkg.sv ***
package ttw_pkg;
  // Walk sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ISSUE = 3'b001,
    ST_RD0 = 3'b010,
    ST_RD1 = 3'b011,
    ST_DECIDE = 3'b100,
    ST_UPD = 3'b101,
    ST_FILL = 3'b110,
    ST_FAULT = 3'b111
  } ttw_state_e;

  // Fault causes
  typedef enum logic [1:0] {
    FC_NONE = 2'b00,
    FC_INVALID = 2'b01,
    FC_LIMIT = 2'b10,
    FC_INDIRECT = 2'b11
  } ttw_cause_e;
endpackage

// *** rtl/ttw_index.sv ***
`timescale 1ns/1ps
`default_nettype none
module ttw_index
  import ttw_pkg::*;
#(
  parameter int LV = 5
) (
  // Address and layout
  input wire logic [31:0] vaddr,
  input wire logic [3:0] shift,
  input wire logic [4*LV-1:0] widths,
  // Level selects
  input wire logic [2:0] nsel,
  input wire logic [2:0] nlev,
  // Results
  output logic [14:0] idx,
  output logic [31:0] offs_mask,
  output logic [31:0] page_mask
);
  // Bits consumed above each level, initial shift first
  wire [6:0] cum [0:LV+1];
  assign cum[0] = {3'h0, shift};
  for (genvar g = 0; g < LV; g++) begin : g_cum
    assign cum[g+1] = cum[g] + {3'h0, widths[4*g +: 4]};
  end
  assign cum[LV+1] = cum[LV];

  // Window of the selected level
  wire [6:0] c_lo = cum[nsel];
  wire [6:0] c_hi = cum[nsel + 3'h1];
  wire [6:0] c_pg = cum[nlev];
  wire [6:0] wn = c_hi - c_lo;
  wire [6:0] rsh = 7'd32 - c_hi;
  wire [31:0] raw = vaddr >> rsh;
  wire [14:0] wmask = (15'h1 << wn) - 15'h1;

  // Upper shifted-out bits fall outside every mask and are never checked
  assign idx = (c_hi > 7'd32) ? 15'h0 : (raw[14:0] & wmask);
  assign offs_mask = (c_lo >= 7'd32) ? 32'h0 : ~(32'hffff_ffff << (7'd32 - c_lo));
  assign page_mask = (c_pg >= 7'd32) ? 32'h0 : ~(32'hffff_ffff << (7'd32 - c_pg));
endmodule
`default_nettype wire

// *** rtl/ttw_irq.sv ***
`timescale 1ns/1ps
`default_nettype none
module ttw_irq
  import ttw_pkg::*;
#(
  parameter int N = 2
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Events and software access
  input wire logic [N-1:0] ev_set,
  input wire logic clr_we,
  input wire logic mask_we,
  input wire logic [N-1:0] wdata,
  // State
  output logic [N-1:0] status_q,
  output logic [N-1:0] mask_q,
  output logic irq_q
);
  // Sticky status, write one to clear, a new event wins
  always_ff @(posedge mclk) begin
    if (srst) begin
      status_q <= '0;
      mask_q <= '0;
      irq_q <= 1'b0;
    end else begin
      status_q <= (status_q & ~(clr_we ? wdata : '0)) | ev_set;
      if (mask_we) begin
        mask_q <= wdata;
      end
      irq_q <= |(status_q & mask_q);
    end
  end
endmodule
`default_nettype wire

// *** testbench/ttw_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Descriptor memory of 256 words, answering promptly or after three waits
module ttw_mem_model (
  // Clock, reset and pacing
  input wire logic mclk,
  input wire logic srst,
  input wire logic slow,
  // Request side
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  // Word store, loaded by the bench
  logic [31:0] mem [0:255];
  // Waits spent on the current request
  logic [2:0] wait_q;
  // Known start levels
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 32'h5a5a_a5a5;
  end
  // Idle data lines scramble every cycle; an answer is one ack pulse
  always @(posedge mclk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (srst) begin
      wait_q <= 3'h0;
    end else if (mem_req && !mem_ack) begin
      if (!slow || wait_q == 3'h3) begin
        mem_ack <= 1'b1;
        wait_q <= 3'h0;
        if (mem_we) begin
          mem[mem_addr[9:2]] <= mem_wdata;
        end else begin
          mem_rdata <= mem[mem_addr[9:2]];
        end
      end else begin
        wait_q <= wait_q + 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench/translation_table_walk_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ttw_map.svh"
module translation_table_walk_test;
  // Stimulus, all known at time zero
  logic mclk = 1'b0, srst = 1'b1, slow = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, walk_vaddr = 32'h0;
  logic walk_req = 1'b0, walk_write = 1'b0;
  logic [2:0] walk_fc = 3'h0;
  // Design outputs and memory lines
  logic [31:0] prdata, cache_fill_vpage, cache_fill_ppage, mem_addr, mem_wdata, mem_rdata;
  logic pready, pslverr, walk_busy, walk_fault, cache_fill_valid, mem_req, mem_we, mem_ack, irq;
  // Last results and tallies
  logic [31:0] rdv;
  logic erv, fl, ft;
  int fail_count = 0, checks = 0;

  always #2.5 mclk = ~mclk;

  ttw_walk #(.LV(5)) dut_u (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .walk_req(walk_req), .walk_vaddr(walk_vaddr), .walk_write(walk_write), .walk_fc(walk_fc),
    .walk_busy(walk_busy), .walk_fault(walk_fault), .cache_fill_valid(cache_fill_valid),
    .cache_fill_vpage(cache_fill_vpage), .cache_fill_ppage(cache_fill_ppage), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .irq(irq));

  ttw_mem_model mem_u (.mclk(mclk), .srst(srst), .slow(slow), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  // Verdict and end of run
  task automatic conclude();
    if (fail_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Value comparison
  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer, request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      conclude();
    end
  endtask

  // Register read and compare
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string name);
    apb(1'b0, a, 32'h0);
    cmp(name, exp, rdv);
  endtask

  // Control word: levels, initial shift, function-code lookup, enabled
  function automatic logic [31:0] ctl(input int lv, input int sh, input logic fcl);
    return (32'(lv) << 8) | (32'(sh) << 4) | {30'h0, fcl, 1'b1};
  endfunction

  // Memory word access behind the design
  task automatic mset(input logic [9:0] a, input logic [31:0] v);
    mem_u.mem[a[9:2]] = v;
  endtask
  function automatic logic [31:0] mget(input logic [9:0] a);
    return mem_u.mem[a[9:2]];
  endfunction

  // One walk request; waits for the fill or fault pulse
  task automatic walk(input logic [31:0] va, input logic wr, input logic [2:0] fc);
    int n;
    n = 0;
    @(posedge mclk);
    walk_req <= 1'b1;
    walk_vaddr <= va;
    walk_write <= wr;
    walk_fc <= fc;
    @(posedge mclk);
    walk_req <= 1'b0;
    do begin
      @(posedge mclk);
      n++;
      if (n == 1) begin
        cmp("busy", 32'h1, {31'h0, walk_busy});
      end
    end while (cache_fill_valid !== 1'b1 && walk_fault !== 1'b1 && n < 300);
    fl = cache_fill_valid;
    ft = walk_fault;
    cmp("busy", 32'h0, {31'h0, walk_busy});
    if (fl !== 1'b1 && ft !== 1'b1) begin
      fail_count++;
      conclude();
    end
  endtask

  // Reset values, alignment, level clamp, unmapped access
  task automatic t_regs();
    rdchk(`TTW_A_CTRL, 32'h0, "ctrl");
    rdchk(`TTW_A_MASK, 32'h0, "mask");
    rdchk(`TTW_A_STATUS, 32'h0, "status");
    apb(1'b1, `TTW_A_ROOT, 32'h0000_010f);
    rdchk(`TTW_A_ROOT, 32'h0000_0100, "root");
    apb(1'b1, `TTW_A_CTRL, ctl(7, 0, 1'b0));
    rdchk(`TTW_A_CTRL, 32'h0000_0501, "ctrl");
    apb(1'b0, 8'h20, 32'h0);
    cmp("slverr", 32'h1, {31'h0, erv});
    cmp("unmapped", 32'h0, rdv);
  endtask

  // Zero-level tree: limit check on the root, initial shift
  task automatic t_zero();
    apb(1'b1, `TTW_A_ROOT, 32'h0002_0000);
    apb(1'b1, `TTW_A_CTRL, ctl(0, 0, 1'b0));
    walk(32'h0, 1'b0, 3'h0);
    cmp("fault", 32'h1, {31'h0, ft});
    cmp("fill", 32'h0, {31'h0, fl});
    apb(1'b1, `TTW_A_ROOTLIM, 32'h1);
    walk(32'h0, 1'b0, 3'h0);
    cmp("fill", 32'h1, {31'h0, fl});
    walk(32'hf000_0000, 1'b0, 3'h0);
    cmp("fault", 32'h1, {31'h0, ft});
    apb(1'b1, `TTW_A_CTRL, ctl(0, 4, 1'b0));
    walk(32'hf000_0000, 1'b0, 3'h0);
    cmp("fill", 32'h1, {31'h0, fl});
    apb(1'b1, `TTW_A_ROOT, 32'h0000_0100);
    apb(1'b1, `TTW_A_ROOTLIM, 32'h0);
  endtask

  // Two-level walk, flag write-back, lower-bound limits on root and table
  task automatic t_walk();
    apb(1'b1, `TTW_A_CTRL, ctl(2, 0, 1'b0));
    mset(10'h100, 32'h0000_0002);
    mset(10'h104, 32'h0000_020c);
    mset(10'h200, 32'hab00_0001);
    walk(32'h0, 1'b0, 3'h0);
    cmp("ppage", 32'hab00_0000, cache_fill_ppage);
    cmp("used", 32'hab00_0009, mget(10'h200));
    mset(10'h200, 32'hab00_0001);
    slow <= 1'b1;
    walk(32'h0, 1'b1, 3'h0);
    slow <= 1'b0;
    cmp("modified", 32'hab00_0019, mget(10'h200));
    apb(1'b1, `TTW_A_ROOTLIM, 32'h8000_0001);
    walk(32'h0, 1'b0, 3'h0);
    cmp("fault", 32'h1, {31'h0, ft});
    apb(1'b1, `TTW_A_ROOTLIM, 32'h0);
    mset(10'h100, 32'h8001_0002);
    walk(32'h0, 1'b0, 3'h0);
    cmp("fault", 32'h1, {31'h0, ft});
    mset(10'h100, 32'h0000_0002);
  endtask

  // Indirect page, double indirection, invalid entries
  task automatic t_indirect();
    mset(10'h200, 32'h0000_0302);
    mset(10'h300, 32'hcd00_0001);
    walk(32'h0, 1'b0, 3'h0);
    cmp("ppage", 32'hcd00_0000, cache_fill_ppage);
    cmp("used", 32'hcd00_0009, mget(10'h300));
    cmp("indirect", 32'h0000_0302, mget(10'h200));
    mset(10'h300, 32'h0000_0342);
    walk(32'h0, 1'b0, 3'h0);
    cmp("fault", 32'h1, {31'h0, ft});
    mset(10'h200, 32'hffff_fffc);
    walk(32'h0, 1'b0, 3'h0);
    cmp("fault", 32'h1, {31'h0, ft});
    cmp("fill", 32'h0, {31'h0, fl});
    mset(10'h100, 32'hffff_fffc);
    walk(32'h0, 1'b0, 3'h0);
    cmp("fault", 32'h1, {31'h0, ft});
  endtask

  // Early termination block with a limit, one fill per page
  task automatic t_early();
    mset(10'h100, 32'h0001_0001);
    mset(10'h104, 32'ha000_0000);
    walk(32'h0, 1'b0, 3'h0);
    cmp("ppage", 32'ha000_0000, cache_fill_ppage);
    walk(32'h0100_0000, 1'b0, 3'h0);
    cmp("fill", 32'h1, {31'h0, fl});
    cmp("vpage", 32'h0100_0000, cache_fill_vpage);
    cmp("ppage", 32'ha100_0000, cache_fill_ppage);
    walk(32'h0200_0000, 1'b0, 3'h0);
    cmp("fault", 32'h1, {31'h0, ft});
  endtask

  // Five levels ending in an indirect page
  task automatic t_depth();
    apb(1'b1, `TTW_A_CTRL, ctl(5, 0, 1'b0));
    mset(10'h100, 32'h7fff_0002);
    mset(10'h104, 32'h0000_0200);
    mset(10'h200, 32'h0000_0242);
    mset(10'h240, 32'h0000_0282);
    mset(10'h280, 32'h0000_02c2);
    mset(10'h2c0, 32'h0000_0302);
    mset(10'h300, 32'hee00_0001);
    walk(32'h0, 1'b0, 3'h0);
    cmp("ppage", 32'hee00_0000, cache_fill_ppage);
    cmp("used", 32'hee00_0009, mget(10'h300));
  endtask

  // Function-code table ignores the root limit
  task automatic t_fc();
    apb(1'b1, `TTW_A_CTRL, ctl(2, 0, 1'b1));
    mset(10'h128, 32'h0000_0001);
    mset(10'h12c, 32'h9000_0000);
    walk(32'h0, 1'b0, 3'h5);
    cmp("ppage", 32'h9000_0000, cache_fill_ppage);
  endtask

  // Sticky status, mask and interrupt level
  task automatic t_irq();
    apb(1'b1, `TTW_A_CTRL, ctl(2, 0, 1'b0));
    mset(10'h100, 32'h0000_0002);
    mset(10'h200, 32'hffff_fffc);
    apb(1'b1, `TTW_A_STATUS, 32'h3);
    apb(1'b1, `TTW_A_MASK, 32'h1);
    walk(32'h0, 1'b0, 3'h0);
    repeat (3) @(posedge mclk);
    cmp("irq", 32'h0, {31'h0, irq});
    rdchk(`TTW_A_STATUS, 32'h2, "status");
    mset(10'h200, 32'hab00_0001);
    walk(32'h0, 1'b0, 3'h0);
    repeat (3) @(posedge mclk);
    cmp("irq", 32'h1, {31'h0, irq});
    apb(1'b1, `TTW_A_STATUS, 32'h1);
    repeat (3) @(posedge mclk);
    cmp("irq", 32'h0, {31'h0, irq});
    rdchk(`TTW_A_STATUS, 32'h2, "status");
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    t_regs();
    apb(1'b1, `TTW_A_WIDTHS, 32'h0004_4444);
    t_zero();
    t_walk();
    t_indirect();
    t_early();
    t_depth();
    t_fc();
    t_irq();
    conclude();
  end

  // Hang guard
  initial begin
    repeat (60000) @(posedge mclk);
    fail_count++;
    conclude();
  end
endmodule
`default_nettype wire
